// >>> hdl/angc_regs.sv
`timescale 1ns/10ps
module angc_regs (
  input wire logic clk,                         // 125 MHz clock
  input wire logic rst_n,                       // Synchronous, active low
  input angc_pkg::angc_mgmt_req_type mgmt,      // Management request
  output logic [15:0] rdata,                    // Read data
  output logic rd_valid,                        // Read data strobe
  input wire logic page_valid,                  // Next page received
  input wire logic [15:0] page_word,            // Received code word
  input wire logic strap_variant,               // Strapped-default variant
  input wire logic fd_strap,                    // Full duplex strap level
  input wire logic link_up,                     // Link status level
  output angc_pkg::angc_page_type partner_page, // Partner page fields
  output angc_pkg::angc_cfg_type gigabit_cfg,   // Gigabit settings
  output logic force_master,                    // Manual role is master
  output logic force_slave,                     // Manual role is slave
  output logic cable_test_start                 // Diagnostic start pulse
);
  import angc_pkg::*;

  typedef struct packed {
    angc_page_type partner;
    angc_cfg_type cfg;
    logic [15:0] rdata;
    logic rd_valid;
    logic link_q;
    logic strap_pending;
    logic force_master;
    logic force_slave;
    logic cable_start;
  } angc_state_type;

  localparam angc_page_type ANGC_PAGE_RESET = '{
    next_page_flag: ANGC_NEXT_PAGE_RESET,
    ack: ANGC_ACK_RESET,
    message_page_flag: ANGC_MSG_RESET,
    partner_comply_flag: ANGC_COMPLY_RESET,
    page_toggle: ANGC_TOG_RESET,
    code: ANGC_NULL_CODE
  };

  localparam angc_cfg_type ANGC_CFG_RESET = '{
    test_mode: ANGC_TM_NORMAL,
    manual_ms: ANGC_MANUAL_RESET,
    ms_value: ANGC_MSVAL_RESET,
    multi_port: ANGC_PORT_RESET,
    adv_1000_fd: ANGC_FD_RESET,
    adv_1000_hd: ANGC_HD_RESET,
    cable_reflect_test_auto: ANGC_CABLE_TEST_RESET,
    reserved: ANGC_RSVD_ZERO
  };

  angc_state_type state;
  angc_state_type next_state;
  angc_page_type cap_page;
  logic cap_load;
  angc_page_type wr_page;
  angc_cfg_type wr_cfg;
  logic wr_partner;
  logic wr_giga;
  logic link_down;

  // ========================================================================
  // Received page latch
  angc_page_capture u_capture (
    .clk(clk),
    .rst_n(rst_n),
    .page_valid(page_valid),
    .page_word(page_word),
    .page(cap_page),
    .page_load(cap_load)
  );

  // ========================================================================
  // Address decode and write views
  assign wr_partner = mgmt.wr_en && (mgmt.addr == ANGC_ADDR_PARTNER_PAGE);
  assign wr_giga = mgmt.wr_en && (mgmt.addr == ANGC_ADDR_GIGA_CFG);
  assign wr_page = angc_page_type'(mgmt.wdata);
  assign wr_cfg = angc_cfg_type'(mgmt.wdata);
  assign link_down = state.link_q && !link_up;

  // ========================================================================
  // Next state
  always_comb begin
    next_state = state;
    // Software may rewrite the writable partner fields
    if (wr_partner) begin
      next_state.partner.next_page_flag = wr_page.next_page_flag;
      next_state.partner.message_page_flag = wr_page.message_page_flag;
      next_state.partner.partner_comply_flag = wr_page.partner_comply_flag;
      next_state.partner.code = wr_page.code;
    end
    // A page arriving with a write wins, so no received page is lost
    if (cap_load) begin
      next_state.partner = cap_page;
    end
    // Gigabit settings; reserved bits drop the written value
    if (wr_giga) begin
      next_state.cfg = wr_cfg;
      next_state.cfg.reserved = ANGC_RSVD_ZERO;
    end
    // Strap is caught once, the cycle after reset release
    next_state.strap_pending = 1'b0;
    if (state.strap_pending && strap_variant && !wr_giga) begin
      next_state.cfg.adv_1000_fd = fd_strap;
    end
    // Role force only counts while manual control is on
    next_state.force_master = next_state.cfg.manual_ms &&
      next_state.cfg.ms_value;
    next_state.force_slave = next_state.cfg.manual_ms &&
      !next_state.cfg.ms_value;
    // Diagnostic start on the falling edge of link
    next_state.link_q = link_up;
    next_state.cable_start = link_down &&
      state.cfg.cable_reflect_test_auto;
    // Read answer one cycle after the strobe
    next_state.rd_valid = mgmt.rd_en;
    if (mgmt.rd_en) begin
      case (mgmt.addr)
        ANGC_ADDR_PARTNER_PAGE: begin
          next_state.rdata = 16'(state.partner);
        end
        ANGC_ADDR_GIGA_CFG: begin
          next_state.rdata = 16'(state.cfg);
        end
        default: begin
          next_state.rdata = ANGC_UNMAPPED_READ;
        end
      endcase
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= '0;
      state.partner <= ANGC_PAGE_RESET;
      state.cfg <= ANGC_CFG_RESET;
      state.strap_pending <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // ========================================================================
  // Outputs, all straight from the state register
  assign rdata = state.rdata;
  assign rd_valid = state.rd_valid;
  assign partner_page = state.partner;
  assign gigabit_cfg = state.cfg;
  assign force_master = state.force_master;
  assign force_slave = state.force_slave;
  assign cable_test_start = state.cable_start;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  angc_page_type rx_view;
  assign rx_view = angc_page_type'(page_word);

  // Continue flag follows the received word two edges later
  a_next_page_load: assert property (
    page_valid |-> ##2
      partner_page.next_page_flag == $past(rx_view.next_page_flag, 2))
    else $error("next page flag not loaded from received word");

  // Acknowledge ignores software writes
  a_ack_read_only: assert property (
    (wr_partner && !cap_load) |=> $stable(partner_page.ack))
    else $error("acknowledge bit changed by a write");

  // Message page flag resets to one
  a_msg_reset_one: assert property (
    !$past(rst_n) |-> partner_page.message_page_flag)
    else $error("message page flag not one after reset");

  // Comply flag follows the received word
  a_comply_load: assert property (
    page_valid |-> ##2 partner_page.partner_comply_flag ==
      $past(rx_view.partner_comply_flag, 2))
    else $error("comply flag not loaded");

  // Stored toggle is the inverse of the exchanged one
  a_toggle_inverse: assert property (
    page_valid |-> ##2
      partner_page.page_toggle == !$past(rx_view.page_toggle, 2))
    else $error("toggle not inverted");

  // Code field follows the received word
  a_code_load: assert property (
    page_valid |-> ##2 partner_page.code == $past(rx_view.code, 2))
    else $error("code field not loaded");

  // Null page code after reset
  a_null_code_reset: assert property (
    !$past(rst_n) |-> partner_page.code == ANGC_NULL_CODE)
    else $error("code field not null after reset");

  // Test mode takes the written value
  a_test_mode_write: assert property (
    wr_giga |=> gigabit_cfg.test_mode == $past(wr_cfg.test_mode))
    else $error("test mode not written");

  // Without manual control no role is forced
  a_role_free: assert property (
    !gigabit_cfg.manual_ms |-> !force_master && !force_slave)
    else $error("role forced while manual control off");

  // Manual value selects the forced role
  a_role_force: assert property (
    gigabit_cfg.manual_ms |->
      force_master == gigabit_cfg.ms_value &&
      force_slave == !gigabit_cfg.ms_value)
    else $error("forced role does not match value");

  // Port type resets to single-port
  a_port_reset: assert property (
    !$past(rst_n) |-> !gigabit_cfg.multi_port)
    else $error("port type not single after reset");

  // Full duplex advert takes the strap in the strapped variant
  a_fd_strap: assert property (
    (!$past(rst_n) && strap_variant) |=>
      (gigabit_cfg.adv_1000_fd == $past(fd_strap) || $past(wr_giga)))
    else $error("full duplex advert not taken from strap");

  // Half duplex advert resets to one
  a_hd_reset: assert property (
    !$past(rst_n) |-> gigabit_cfg.adv_1000_hd)
    else $error("half duplex advert not one after reset");

  // Diagnostic start follows each link drop when enabled
  a_auto_cable_test: assert property (
    ($fell(link_up) && gigabit_cfg.cable_reflect_test_auto)
      |=> cable_test_start ##1 !cable_test_start)
    else $error("cable diagnostic not started after link down");

  // No start without the enable
  a_cable_test_quiet: assert property (
    cable_test_start |-> $past(gigabit_cfg.cable_reflect_test_auto))
    else $error("cable diagnostic started while disabled");

  // Reserved bits read zero
  a_rsvd_zero: assert property (
    gigabit_cfg.reserved == ANGC_RSVD_ZERO)
    else $error("reserved bits not zero");

  // Config read answers at its address
  a_cfg_read: assert property (
    (mgmt.rd_en && mgmt.addr == ANGC_ADDR_GIGA_CFG) |=>
      rd_valid && rdata == 16'($past(gigabit_cfg)))
    else $error("config read data wrong");

  c_page_rx: cover property (page_valid ##2 partner_page.next_page_flag);
  c_cfg_write_read: cover property (wr_giga ##1
    (mgmt.rd_en && mgmt.addr == ANGC_ADDR_GIGA_CFG));
  c_force_master: cover property ($rose(force_master));
  c_cable_test_start: cover property (cable_test_start);

endmodule

// >>> include/angc_pkg.sv
// ==========================================================================
// Shared constants and types for the next-page / gigabit config bank
package angc_pkg;

  // ========================================================================
  // Management register addresses
  localparam logic [4:0] ANGC_ADDR_PARTNER_PAGE = 5'h08; // Partner next page
  localparam logic [4:0] ANGC_ADDR_GIGA_CFG = 5'h09; // Gigabit config

  // ========================================================================
  // Reset values
  localparam logic ANGC_NEXT_PAGE_RESET = 1'h0;
  localparam logic ANGC_ACK_RESET = 1'h0;
  localparam logic ANGC_MSG_RESET = 1'h1;
  localparam logic ANGC_COMPLY_RESET = 1'h0;
  localparam logic ANGC_TOG_RESET = 1'h0;
  localparam logic [10:0] ANGC_NULL_CODE = 11'h001; // Null page code
  localparam logic ANGC_MANUAL_RESET = 1'h0;
  localparam logic ANGC_MSVAL_RESET = 1'h0;
  localparam logic ANGC_PORT_RESET = 1'h0;
  localparam logic ANGC_FD_RESET = 1'h1;
  localparam logic ANGC_HD_RESET = 1'h1;
  localparam logic ANGC_CABLE_TEST_RESET = 1'h0;
  localparam logic [6:0] ANGC_RSVD_ZERO = 7'h00;
  localparam logic [15:0] ANGC_UNMAPPED_READ = 16'h0000;

  // ========================================================================
  // Transmit test modes, in code order 000 to 111
  typedef enum logic [2:0] {
    ANGC_TM_NORMAL,
    ANGC_TM_WAVEFORM,
    ANGC_TM_JITTER_MASTER,
    ANGC_TM_JITTER_SLAVE,
    ANGC_TM_DISTORTION,
    ANGC_TM_SCRAMBLED_IDLE,
    ANGC_TM_REPEAT_0001,
    ANGC_TM_PULSE_63_ZERO
  } angc_test_mode_type;

  // ========================================================================
  // Register layouts, most significant field first
  typedef struct packed {
    logic next_page_flag;      // More pages wanted by partner
    logic ack;                 // Partner acknowledged code word
    logic message_page_flag;   // Message page, else unformatted
    logic partner_comply_flag; // Partner can comply
    logic page_toggle;         // Opposite of last exchanged toggle
    logic [10:0] code;         // Message or unformatted code
  } angc_page_type;

  typedef struct packed {
    angc_test_mode_type test_mode; // Transmit test mode
    logic manual_ms;               // Manual master/slave enable
    logic ms_value;                // 1 master, 0 slave
    logic multi_port;              // Advertise multi-port device
    logic adv_1000_fd;             // Advertise 1000BASE-T full duplex
    logic adv_1000_hd;             // Advertise 1000BASE-T half duplex
    logic cable_reflect_test_auto; // Diagnostic after link down
    logic [6:0] reserved;          // Always zero
  } angc_cfg_type;

  // Management access request, taken in one cycle
  typedef struct packed {
    logic [4:0] addr;  // Register address
    logic wr_en;       // Write strobe
    logic rd_en;       // Read strobe
    logic [15:0] wdata; // Write data
  } angc_mgmt_req_type;

endpackage

// >>> hdl/angc_page_capture.sv
`timescale 1ns/10ps
// ==========================================================================
// Latches each received next-page code word into register layout
module angc_page_capture (
  input wire logic clk,                      // 125 MHz clock
  input wire logic rst_n,                    // Synchronous reset
  input wire logic page_valid,               // Received code word strobe
  input wire logic [15:0] page_word,         // Received code word
  output angc_pkg::angc_page_type page,      // Captured page
  output logic page_load                     // One-cycle load pulse
);
  import angc_pkg::*;

  typedef struct packed {
    logic load;
    angc_page_type page;
  } angc_cap_state_type;

  angc_cap_state_type state;
  angc_cap_state_type next_state;
  angc_page_type rx;

  // ========================================================================
  // Next state: the stored toggle is the opposite of the word's toggle
  always_comb begin
    rx = angc_page_type'(page_word);
    next_state = state;
    next_state.load = page_valid;
    if (page_valid) begin
      next_state.page = rx;
      next_state.page.page_toggle = ~rx.page_toggle;
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign page = state.page;
  assign page_load = state.load;

endmodule

// >>> bench/tb_top.sv
`timescale 1ns/10ps
// ==========================================================================
// Self-checking bench for the partner page and gigabit config bank
module tb_top;
  import angc_pkg::*;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  angc_mgmt_req_type mgmt = '0;
  logic page_valid = 1'b0;
  logic [15:0] page_word = 16'h0000;
  logic strap_variant = 1'b0;
  logic fd_strap = 1'b1;
  logic link_up = 1'b1;
  logic [15:0] rdata;
  logic rd_valid;
  angc_page_type partner_page;
  angc_cfg_type gigabit_cfg;
  logic force_master;
  logic force_slave;
  logic cable_test_start;
  int err_total = 0;
  int cmp_count = 0;
  int i;
  int pulses;

  // ========================================================================
  // Clock and device under test
  // Free-running 125 MHz clock
  always #4 clk = ~clk;

  angc_regs dut (
    .clk(clk),
    .rst_n(rst_n),
    .mgmt(mgmt),
    .rdata(rdata),
    .rd_valid(rd_valid),
    .page_valid(page_valid),
    .page_word(page_word),
    .strap_variant(strap_variant),
    .fd_strap(fd_strap),
    .link_up(link_up),
    .partner_page(partner_page),
    .gigabit_cfg(gigabit_cfg),
    .force_master(force_master),
    .force_slave(force_slave),
    .cable_test_start(cable_test_start)
  );

  // ========================================================================
  // Access tasks
  // Compare with case equality so an unknown never passes
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe; result is visible at the following fall
  task automatic wr(input logic [4:0] addr, input logic [15:0] data);
    @(negedge clk);
    mgmt.addr = addr;
    mgmt.wdata = data;
    mgmt.wr_en = 1'b1;
    @(negedge clk);
    mgmt.wr_en = 1'b0;
  endtask

  // One-cycle read strobe, then a bounded wait for the data strobe
  task automatic rd(input logic [4:0] addr, input logic [15:0] exp);
    int n;
    @(negedge clk);
    mgmt.addr = addr;
    mgmt.rd_en = 1'b1;
    @(negedge clk);
    mgmt.rd_en = 1'b0;
    n = 0;
    while (rd_valid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    chk({15'h0000, rd_valid}, 16'h0001);
    chk(rdata, exp);
  endtask

  // Present one received code word for a single cycle
  task automatic page(input logic [15:0] w);
    @(negedge clk);
    page_word = w;
    page_valid = 1'b1;
  endtask

  // Drop the strobe, then allow the two-stage capture to land
  task automatic page_end;
    @(negedge clk);
    page_valid = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // Drop the link and count diagnostic start pulses
  task automatic drop(input logic [15:0] expn);
    pulses = 0;
    @(negedge clk);
    link_up = 1'b0;
    repeat (4) begin
      @(negedge clk);
      if (cable_test_start === 1'b1) begin
        pulses++;
      end
    end
    link_up = 1'b1;
    chk(pulses[15:0], expn);
  endtask

  // Reset held eight cycles with the chosen strap setting
  task automatic do_reset(input logic var_sel, input logic strap);
    @(negedge clk);
    rst_n = 1'b0;
    strap_variant = var_sel;
    fd_strap = strap;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
  endtask

  task automatic wrap_up;
    $display("compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ========================================================================
  // Test sequence
  initial begin
    do_reset(1'b0, 1'b1);
    rd(ANGC_ADDR_PARTNER_PAGE, 16'h2001);
    chk(partner_page, 16'h2001);
    rd(ANGC_ADDR_GIGA_CFG, 16'h0300);
    chk(gigabit_cfg, 16'h0300);
    chk({14'h0000, force_master, force_slave}, 16'h0000);
    $display("test reset values done");
    // Reserved bits must drop out of an all-ones write
    wr(ANGC_ADDR_GIGA_CFG, 16'hffff);
    rd(ANGC_ADDR_GIGA_CFG, 16'hff80);
    chk({14'h0000, force_master, force_slave}, 16'h0002);
    wr(ANGC_ADDR_GIGA_CFG, 16'h1400);
    rd(ANGC_ADDR_GIGA_CFG, 16'h1400);
    chk({14'h0000, force_master, force_slave}, 16'h0001);
    // Hand the role back to negotiation so no forced role lingers
    wr(ANGC_ADDR_GIGA_CFG, 16'h0800);
    chk({14'h0000, force_master, force_slave}, 16'h0000);
    for (i = 0; i < 8; i++) begin
      wr(ANGC_ADDR_GIGA_CFG, {i[2:0], 13'h0000});
      chk({13'h0000, gigabit_cfg.test_mode}, {13'h0000, i[2:0]});
    end
    $display("test config fields done");
    // Read-only flags keep their values under an all-ones write
    wr(ANGC_ADDR_PARTNER_PAGE, 16'hffff);
    rd(ANGC_ADDR_PARTNER_PAGE, 16'hb7ff);
    page(16'hd5aa);
    page_end;
    chk(partner_page, 16'hddaa);
    chk({15'h0000, partner_page.partner_comply_flag}, 16'h0001);
    // Back to back pages, the later one must win
    page(16'h2801);
    page(16'h4c33);
    page_end;
    chk(partner_page, 16'h4433);
    rd(ANGC_ADDR_PARTNER_PAGE, 16'h4433);
    $display("test partner pages done");
    // Unmapped address reads zero and ignores writes
    wr(5'h0a, 16'hffff);
    rd(5'h0a, 16'h0000);
    // Config still holds test mode 7 from the last loop write
    rd(ANGC_ADDR_GIGA_CFG, 16'he000);
    $display("test address decode done");
    wr(ANGC_ADDR_GIGA_CFG, 16'h0380);
    drop(16'h0001);
    wr(ANGC_ADDR_GIGA_CFG, 16'h0300);
    drop(16'h0000);
    $display("test link drop done");
    // Strapped variant takes full duplex advert from the strap level
    do_reset(1'b1, 1'b0);
    repeat (3) @(negedge clk);
    rd(ANGC_ADDR_GIGA_CFG, 16'h0100);
    do_reset(1'b1, 1'b1);
    repeat (3) @(negedge clk);
    rd(ANGC_ADDR_GIGA_CFG, 16'h0300);
    $display("test strap variant done");
    wrap_up;
  end

  // Whole run needs about a hundred cycles; this limit is far beyond it
  initial begin
    #50000;
    err_total++;
    $display("watchdog expired at %0t ns", $time);
    wrap_up;
  end
endmodule
